// [src/iorsd_pkg.sv]
// constants and register map for the i/o register space decoder
// Behaviour
// [RULE1] bit set/clear only at addresses 0x00-0x1F
// [RULE2] bit test allowed in bit-accessible range
// [RULE3] some flags clear on writing one
// [RULE4] bit set/clear touches only addressed bit
// [RULE5] in/out instructions use addresses 0x00-0x3F
// [RULE6] data-space access maps at i/o plus 0x20
// [RULE7] software writes zero to reserved bits
// [RULE8] software never writes reserved addresses
// [RULE9] reserved reads zero, writes ignored
// [RULE10] flag reads don't clear; single-cycle access
package iorsd_pkg;
  localparam int unsigned IO_AW = 6;
  localparam int unsigned DW = 8;
  localparam logic [5:0] BIT_MAX_ADDR = 6'h1F;
  localparam logic [7:0] DATA_OFFSET = 8'h20;
  localparam logic [7:0] DATA_LAST = 8'h5F;
  localparam logic [5:0] A_CMP_DIS = 6'h01;
  localparam logic [5:0] A_BAUD_HI = 6'h02;
  localparam logic [5:0] A_FRAME_CFG = 6'h03;
  localparam logic [5:0] A_CMP_CS = 6'h08;
  localparam logic [5:0] A_BAUD_LO = 6'h09;
  localparam logic [5:0] A_SER_CTL = 6'h0A;
  localparam logic [5:0] A_SER_STAT = 6'h0B;
  localparam logic [5:0] A_SER_DATA = 6'h0C;
  localparam logic [5:0] A_USI_CTL = 6'h0D;
  localparam logic [5:0] A_USI_STAT = 6'h0E;
  localparam logic [5:0] A_USI_DATA = 6'h0F;
  localparam logic [5:0] A_PD_PIN = 6'h10;
  localparam logic [5:0] A_PD_DIR = 6'h11;
  localparam logic [5:0] A_PD_OUT = 6'h12;
  localparam logic [5:0] A_SCR0 = 6'h13;
  localparam logic [5:0] A_SCR1 = 6'h14;
  localparam logic [5:0] A_SCR2 = 6'h15;
  localparam logic [5:0] A_PB_PIN = 6'h16;
  localparam logic [5:0] A_PB_DIR = 6'h17;
  localparam logic [5:0] A_PB_OUT = 6'h18;
  // writable-bit masks, reserved bits are zero
  localparam logic [7:0] M_CMP_DIS = 8'h03;
  localparam logic [7:0] M_BAUD_HI = 8'h0F;
  localparam logic [7:0] M_FRAME_CFG = 8'h7F;
  localparam logic [7:0] M_PORT_D = 8'h7F;
  localparam logic [7:0] M_ALL = 8'hFF;
  // write-one-to-clear flag masks
  localparam logic [7:0] W1C_CMP_CS = 8'h10;
  localparam logic [7:0] W1C_SER_STAT = 8'h40;
  localparam logic [7:0] W1C_USI_STAT = 8'hE0;
  // hardware-owned read-only bits inside mixed registers
  localparam logic [7:0] HW_CMP_CS = 8'h20;
  localparam logic [7:0] HW_SER_STAT = 8'hBC;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [7:0] RST_SER_STAT = 8'h20;
  typedef enum logic [3:0] {
    IORSD_OP_NONE = 4'h0,
    IORSD_OP_IN = 4'h1,
    IORSD_OP_OUT = 4'h2,
    IORSD_OP_SET_IO_BIT_INSTR = 4'h3,
    IORSD_OP_CLEAR_IO_BIT_INSTR = 4'h4,
    IORSD_OP_SKIP_IF_IO_BIT_SET_INSTR = 4'h5,
    IORSD_OP_SKIP_IF_IO_BIT_CLEAR_INSTR = 4'h6,
    IORSD_OP_DATA_SPACE_LOAD_INSTR = 4'h7,
    IORSD_OP_DATA_SPACE_STORE_INSTR = 4'h8
  } iorsd_op_t;
endpackage

// [src/iorsd_decoder.sv]
// i/o register space decoder: io, bit and data-space access
`timescale 1ns/1ns
`default_nettype none
module iorsd_decoder (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [3:0] i_op,
  input wire logic [7:0] i_addr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_port_b_pins,
  input wire logic [6:0] i_port_d_pins,
  input wire logic [7:0] i_flag_set,
  input wire logic [7:0] i_hw_status,
  output logic [7:0] o_rdata,
  output logic o_skip,
  output logic o_hit,
  output logic [7:0] o_port_b_out,
  output logic [7:0] o_port_b_dir,
  output logic [6:0] o_port_d_out,
  output logic [6:0] o_port_d_dir
);
  // i_flag_set: [0] comparator irq flag, [1] serial tx done, [4:2] usi start/overflow/stop
  // i_hw_status: [0] comparator output, [1] serial rx, [5:2] serial udre/fe/dor/upe
  localparam int unsigned NREG = 64;
  logic [7:0] regs_ff [NREG];
  logic [7:0] nxt_regs [NREG];
  logic [7:0] pb_s1_ff, pb_s2_ff;
  logic [6:0] pd_s1_ff, pd_s2_ff;
  logic [7:0] rdata_ff, nxt_rdata;
  logic skip_ff, nxt_skip;
  logic hit_ff, nxt_hit;
  logic [5:0] io_a;
  logic in_range, is_wr, is_rd, is_bit_set, is_bit_clr, is_test;
  logic [7:0] sel_mask, cur_val, w1c_m, bitmask;
  logic [7:0] hw_fset [NREG];

  // address translation: data space subtracts the offset
  always_comb begin
    io_a = i_addr[5:0];
    in_range = 1'b0;
    unique case (iorsd_pkg::iorsd_op_t'(i_op))
      iorsd_pkg::IORSD_OP_DATA_SPACE_LOAD_INSTR, iorsd_pkg::IORSD_OP_DATA_SPACE_STORE_INSTR: begin
        io_a = 6'(i_addr - iorsd_pkg::DATA_OFFSET); // [RULE6]
        in_range = (i_addr >= iorsd_pkg::DATA_OFFSET) && (i_addr <= iorsd_pkg::DATA_LAST);
      end
      iorsd_pkg::IORSD_OP_IN, iorsd_pkg::IORSD_OP_OUT: begin
        in_range = (i_addr[7:6] == 2'b00); // [RULE5]
      end
      iorsd_pkg::IORSD_OP_SET_IO_BIT_INSTR, iorsd_pkg::IORSD_OP_CLEAR_IO_BIT_INSTR,
      iorsd_pkg::IORSD_OP_SKIP_IF_IO_BIT_SET_INSTR, iorsd_pkg::IORSD_OP_SKIP_IF_IO_BIT_CLEAR_INSTR: begin
        in_range = (i_addr <= {2'b00, iorsd_pkg::BIT_MAX_ADDR}); // [RULE1] [RULE2]
      end
      default: in_range = 1'b0;
    endcase
  end

  // access classes and per-register masks
  always_comb begin
    is_wr = in_range && (i_op == iorsd_pkg::IORSD_OP_OUT || i_op == iorsd_pkg::IORSD_OP_DATA_SPACE_STORE_INSTR);
    is_rd = in_range && (i_op == iorsd_pkg::IORSD_OP_IN || i_op == iorsd_pkg::IORSD_OP_DATA_SPACE_LOAD_INSTR);
    is_bit_set = in_range && (i_op == iorsd_pkg::IORSD_OP_SET_IO_BIT_INSTR);
    is_bit_clr = in_range && (i_op == iorsd_pkg::IORSD_OP_CLEAR_IO_BIT_INSTR);
    is_test = in_range && (i_op == iorsd_pkg::IORSD_OP_SKIP_IF_IO_BIT_SET_INSTR ||
      i_op == iorsd_pkg::IORSD_OP_SKIP_IF_IO_BIT_CLEAR_INSTR);
    bitmask = 8'h01 << i_bit;
    w1c_m = 8'h00;
    unique case (io_a)
      iorsd_pkg::A_CMP_DIS: sel_mask = iorsd_pkg::M_CMP_DIS;
      iorsd_pkg::A_BAUD_HI: sel_mask = iorsd_pkg::M_BAUD_HI;
      iorsd_pkg::A_FRAME_CFG: sel_mask = iorsd_pkg::M_FRAME_CFG;
      iorsd_pkg::A_CMP_CS: begin
        sel_mask = iorsd_pkg::M_ALL & ~iorsd_pkg::HW_CMP_CS & ~iorsd_pkg::W1C_CMP_CS;
        w1c_m = iorsd_pkg::W1C_CMP_CS;
      end
      iorsd_pkg::A_SER_STAT: begin
        sel_mask = iorsd_pkg::M_ALL & ~iorsd_pkg::HW_SER_STAT & ~iorsd_pkg::W1C_SER_STAT;
        w1c_m = iorsd_pkg::W1C_SER_STAT;
      end
      iorsd_pkg::A_USI_STAT: begin
        sel_mask = iorsd_pkg::M_ALL & ~iorsd_pkg::W1C_USI_STAT;
        w1c_m = iorsd_pkg::W1C_USI_STAT;
      end
      iorsd_pkg::A_BAUD_LO, iorsd_pkg::A_SER_CTL, iorsd_pkg::A_SER_DATA, iorsd_pkg::A_USI_CTL,
      iorsd_pkg::A_USI_DATA, iorsd_pkg::A_SCR0, iorsd_pkg::A_SCR1, iorsd_pkg::A_SCR2,
      iorsd_pkg::A_PB_DIR, iorsd_pkg::A_PB_OUT: sel_mask = iorsd_pkg::M_ALL;
      iorsd_pkg::A_PD_DIR, iorsd_pkg::A_PD_OUT: sel_mask = iorsd_pkg::M_PORT_D;
      default: sel_mask = 8'h00; // reserved and pin registers take no writes [RULE9]
    endcase
  end

  // hardware event sets per register, routed by generate
  generate
    for (genvar g = 0; g < NREG; g++) begin : g_fset
      if (g == iorsd_pkg::A_CMP_CS) begin : g_c
        assign hw_fset[g] = {3'b000, i_flag_set[0], 4'h0};
      end else if (g == iorsd_pkg::A_SER_STAT) begin : g_s
        assign hw_fset[g] = {1'b0, i_flag_set[1], 6'h00};
      end else if (g == iorsd_pkg::A_USI_STAT) begin : g_u
        assign hw_fset[g] = {i_flag_set[4:2], 5'h00};
      end else begin : g_n
        assign hw_fset[g] = 8'h00;
      end
    end
  endgenerate

  // current value of the addressed register as seen by a read
  always_comb begin
    unique case (io_a)
      iorsd_pkg::A_PB_PIN: cur_val = pb_s2_ff;
      iorsd_pkg::A_PD_PIN: cur_val = {1'b0, pd_s2_ff};
      iorsd_pkg::A_CMP_CS: cur_val = regs_ff[io_a] | ({2'b00, i_hw_status[0], 5'h00} & iorsd_pkg::HW_CMP_CS);
      iorsd_pkg::A_SER_STAT: cur_val = regs_ff[io_a] |
        ({i_hw_status[1], 1'b0, i_hw_status[5:2], 2'b00} & iorsd_pkg::HW_SER_STAT);
      default: cur_val = regs_ff[io_a]; // reserved slots never written, stay zero [RULE9]
    endcase
  end

  // next register state; hardware set wins over software clear
  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      nxt_regs[r] = regs_ff[r];
    end
    if (is_wr) begin
      // plain bits take data, w1c bits drop where a one is written [RULE3]
      nxt_regs[io_a] = (i_wdata & sel_mask) | (regs_ff[io_a] & w1c_m & ~i_wdata);
    end else if (is_bit_set) begin
      // only the addressed bit moves; other w1c flags untouched [RULE4]
      if ((bitmask & w1c_m) != 8'h00) begin
        nxt_regs[io_a] = regs_ff[io_a] & ~bitmask; // set on a flag is a one-write: clear [RULE3]
      end else begin
        nxt_regs[io_a] = regs_ff[io_a] | (bitmask & sel_mask); // [RULE1]
      end
    end else if (is_bit_clr) begin
      nxt_regs[io_a] = regs_ff[io_a] & ~(bitmask & sel_mask); // [RULE4]
    end
    for (int r = 0; r < NREG; r++) begin
      nxt_regs[r] = nxt_regs[r] | hw_fset[r];
    end
  end

  // read data, skip decision and hit, one cycle [RULE10]
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_skip = 1'b0;
    nxt_hit = is_wr || is_rd || is_bit_set || is_bit_clr || is_test;
    if (is_rd) begin
      nxt_rdata = cur_val; // read never clears flags [RULE10]
    end
    if (is_test) begin
      // skip on set or clear of the chosen bit [RULE2]
      nxt_skip = (i_op == iorsd_pkg::IORSD_OP_SKIP_IF_IO_BIT_SET_INSTR) ? cur_val[i_bit] : ~cur_val[i_bit];
    end
  end

  // pin synchronisers: pins come from outside the clock domain
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pb_s1_ff <= 8'h00;
      pb_s2_ff <= 8'h00;
      pd_s1_ff <= 7'h00;
      pd_s2_ff <= 7'h00;
    end else if (i_enable) begin
      pb_s1_ff <= i_port_b_pins;
      pb_s2_ff <= pb_s1_ff;
      pd_s1_ff <= i_port_d_pins;
      pd_s2_ff <= pd_s1_ff;
    end
  end

  // register bank and response flops
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int r = 0; r < NREG; r++) begin
        regs_ff[r] <= (r == iorsd_pkg::A_SER_STAT) ? iorsd_pkg::RST_SER_STAT : iorsd_pkg::RST_VAL;
      end
      rdata_ff <= 8'h00;
      skip_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else if (i_enable) begin
      for (int r = 0; r < NREG; r++) begin
        regs_ff[r] <= nxt_regs[r];
      end
      rdata_ff <= nxt_rdata;
      skip_ff <= nxt_skip;
      hit_ff <= nxt_hit;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_skip = skip_ff;
  assign o_hit = hit_ff;
  assign o_port_b_out = regs_ff[iorsd_pkg::A_PB_OUT];
  assign o_port_b_dir = regs_ff[iorsd_pkg::A_PB_DIR];
  assign o_port_d_out = regs_ff[iorsd_pkg::A_PD_OUT][6:0];
  assign o_port_d_dir = regs_ff[iorsd_pkg::A_PD_DIR][6:0];

  // assertions
  sequence s_bit_op_high;
    i_enable && i_addr > 8'h1F && (i_op == iorsd_pkg::IORSD_OP_SET_IO_BIT_INSTR ||
      i_op == iorsd_pkg::IORSD_OP_CLEAR_IO_BIT_INSTR);
  endsequence
  a_bit_range_only: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE1]
    s_bit_op_high |=> !o_hit) else $error("bit op above range was taken");
  a_skip_set_test: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE2]
    i_enable && i_op == iorsd_pkg::IORSD_OP_SKIP_IF_IO_BIT_SET_INSTR && i_addr == {2'b00, iorsd_pkg::A_SCR0} &&
      regs_ff[iorsd_pkg::A_SCR0][i_bit] |=> o_skip) else $error("skip on set bit missed");
  // bit 7 of the usi status is raised by event line 4, which must be quiet here
  a_w1c_clear: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE3]
    i_enable && i_op == iorsd_pkg::IORSD_OP_OUT && i_addr == {2'b00, iorsd_pkg::A_USI_STAT} &&
      i_wdata[7] && !i_flag_set[4] |=> !regs_ff[iorsd_pkg::A_USI_STAT][7])
    else $error("w1c flag not cleared");
  // a hardware event in the clearing cycle must survive the clear
  a_set_wins_clear: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE3]
    i_enable && i_flag_set[3] |=> regs_ff[iorsd_pkg::A_USI_STAT][6]) else $error("flag set lost to clear");
  a_bit_other_kept: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE4]
    i_enable && i_op == iorsd_pkg::IORSD_OP_SET_IO_BIT_INSTR && i_addr == {2'b00, iorsd_pkg::A_USI_STAT} &&
      i_bit == 3'h0 |=> regs_ff[iorsd_pkg::A_USI_STAT][7:5] ==
      ($past(regs_ff[iorsd_pkg::A_USI_STAT][7:5]) | $past(hw_fset[iorsd_pkg::A_USI_STAT][7:5])))
    else $error("bit op disturbed flags");
  // in/out beyond the 64-slot window is refused outright
  a_io_range_hit: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE5]
    i_enable && (i_op == iorsd_pkg::IORSD_OP_IN || i_op == iorsd_pkg::IORSD_OP_OUT) && i_addr[7:6] != 2'b00 |=>
      !o_hit) else $error("io op outside window taken");
  a_io_out_store: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE5]
    i_enable && i_op == iorsd_pkg::IORSD_OP_OUT && i_addr == {2'b00, iorsd_pkg::A_SCR1} |=>
      regs_ff[iorsd_pkg::A_SCR1] == $past(i_wdata)) else $error("io write not stored");
  a_data_offset: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE6]
    i_enable && i_op == iorsd_pkg::IORSD_OP_DATA_SPACE_STORE_INSTR && i_addr == 8'h33 |=>
      regs_ff[iorsd_pkg::A_SCR0] == $past(i_wdata)) else $error("data-space map wrong");
  a_rsvd_zero: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE9]
    i_enable && i_op == iorsd_pkg::IORSD_OP_IN && i_addr == 8'h05 |=> o_rdata == 8'h00)
    else $error("reserved read not zero");
  // a stray write to an unused slot leaves nothing behind
  a_rsvd_write: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE9]
    i_enable && i_op == iorsd_pkg::IORSD_OP_OUT && i_addr == 8'h05 |=> regs_ff[5] == 8'h00)
    else $error("reserved write stored");
  a_read_keeps: assert property (@(posedge i_clock) disable iff (i_reset) // [RULE10]
    i_enable && i_op == iorsd_pkg::IORSD_OP_IN && i_addr == {2'b00, iorsd_pkg::A_USI_STAT} |=>
      o_hit ##0 regs_ff[iorsd_pkg::A_USI_STAT][7:5] ==
      ($past(regs_ff[iorsd_pkg::A_USI_STAT][7:5]) | $past(hw_fset[iorsd_pkg::A_USI_STAT][7:5])))
    else $error("read disturbed flags");
endmodule
`default_nettype wire

// [bench/iorsd_core_model.sv]
// processor core model issuing i/o, bit and data-space operations
`timescale 1ns/1ns
`default_nettype none
module iorsd_core_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  input wire logic i_skip,
  input wire logic i_hit,
  output logic o_enable,
  output logic [3:0] o_op,
  output logic [7:0] o_addr,
  output logic [2:0] o_bit,
  output logic [7:0] o_wdata
);
  logic polite = 1'b1;
  logic [7:0] rd;
  logic sk;
  logic ht;
  // idle bus, core clocked except while stalled
  initial begin
    o_enable = 1'b1;
    o_op = 4'h0;
    o_addr = 8'h00;
    o_bit = 3'h0;
    o_wdata = 8'h00;
  end
  // one access per call, answer taken half a cycle after the taking edge
  task automatic run(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    @(negedge i_clock);
    // a careful core drops stores to unused slots 0x00 and 0x04-0x07, in either address view
    if (polite && ((op == 4'h2 && (a == 8'h00 || (a >= 8'h04 && a <= 8'h07))) ||
      (op == 4'h8 && (a == 8'h20 || (a >= 8'h24 && a <= 8'h27))))) begin
      o_op = 4'h0;
    end else begin
      o_op = op;
    end
    o_addr = a;
    o_bit = b;
    o_wdata = d;
    @(negedge i_clock);
    rd = i_rdata;
    sk = i_skip;
    ht = i_hit;
    o_op = 4'h0;
    // released qualifiers show junk, not the last value
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // core stalled for one cycle with an op on the bus: nothing may be taken
  task automatic stall(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_enable = 1'b0;
    o_op = op;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clock);
    o_enable = 1'b1;
    o_op = 4'h0;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock, reset, enable, skip, hit;
  logic [3:0] op;
  logic [7:0] addr, wdata, rdata, pb_pins, flag_set, hw_status, pb_out, pb_dir;
  logic [6:0] pd_pins, pd_out, pd_dir;
  logic [2:0] bit_idx;
  int failures, total_checks;
  localparam logic [7:0] SCR = 8'h5A;
  iorsd_decoder uut (.i_clock(clock), .i_reset(reset), .i_enable(enable), .i_op(op), .i_addr(addr),
    .i_bit(bit_idx), .i_wdata(wdata), .i_port_b_pins(pb_pins), .i_port_d_pins(pd_pins), .i_flag_set(flag_set),
    .i_hw_status(hw_status), .o_rdata(rdata), .o_skip(skip), .o_hit(hit), .o_port_b_out(pb_out),
    .o_port_b_dir(pb_dir), .o_port_d_out(pd_out), .o_port_d_dir(pd_dir));
  iorsd_core_model core (.i_clock(clock), .i_rdata(rdata), .i_skip(skip), .i_hit(hit), .o_enable(enable),
    .o_op(op), .o_addr(addr), .o_bit(bit_idx), .o_wdata(wdata));
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access plus its accept flag
  task automatic acc(input logic [3:0] o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
    input logic h);
    core.run(o, a, b, d);
    check("hit", {7'h00, core.ht}, {7'h00, h});
  endtask
  task automatic read_io(input logic [7:0] a, input logic [7:0] exp);
    acc(4'h1, a, 3'h0, 8'h00, 1'b1);
    check("rdata", core.rd, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    #20000;
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    reset = 1'b1;
    pb_pins = 8'h00;
    pd_pins = 7'h00;
    flag_set = 8'h00;
    hw_status = 8'h00;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    read_io(8'h13, 8'h00);
    read_io(8'h0B, 8'h20);
    acc(4'h2, 8'h13, 3'h0, 8'hA5, 1'b1);
    read_io(8'h13, 8'hA5);
    acc(4'h1, 8'h40, 3'h0, 8'h00, 1'b0);
    read_io(8'h3F, 8'h00);
    // data-space window sits 0x20 above the i/o addresses
    acc(4'h2, 8'h14, 3'h0, 8'h3C, 1'b1);
    acc(4'h7, 8'h34, 3'h0, 8'h00, 1'b1);
    check("load", core.rd, 8'h3C);
    acc(4'h8, 8'h33, 3'h0, SCR, 1'b1);
    read_io(8'h13, SCR);
    acc(4'h7, 8'h13, 3'h0, 8'h00, 1'b0);
    acc(4'h8, 8'h60, 3'h0, 8'hFF, 1'b0);
    acc(4'h7, 8'h5F, 3'h0, 8'h00, 1'b1);
    // single-bit set and clear, and the range limit
    acc(4'h3, 8'h18, 3'h3, 8'h00, 1'b1);
    check("pb_out", pb_out, 8'h08);
    acc(4'h3, 8'h18, 3'h7, 8'h00, 1'b1);
    acc(4'h4, 8'h18, 3'h3, 8'h00, 1'b1);
    read_io(8'h18, 8'h80);
    acc(4'h3, 8'h20, 3'h0, 8'h00, 1'b0);
    acc(4'h4, 8'h3F, 3'h0, 8'h00, 1'b0);
    // every bit tested both ways
    for (int i = 0; i < 16; i++) begin
      acc(i < 8 ? 4'h5 : 4'h6, 8'h13, i[2:0], 8'h00, 1'b1);
      check("skip", {7'h00, core.sk}, {7'h00, SCR[i[2:0]] ^ (i >= 8)});
    end
    // comparator flag: raised by hardware, cleared only by writing one
    @(negedge clock);
    flag_set = 8'h01;
    @(negedge clock);
    flag_set = 8'h00;
    read_io(8'h08, 8'h10);
    read_io(8'h08, 8'h10);
    acc(4'h3, 8'h08, 3'h0, 8'h00, 1'b1);
    acc(4'h4, 8'h08, 3'h4, 8'h00, 1'b1);
    read_io(8'h08, 8'h11);
    acc(4'h2, 8'h08, 3'h0, 8'h01, 1'b1);
    read_io(8'h08, 8'h11);
    acc(4'h2, 8'h08, 3'h0, 8'h10, 1'b1);
    read_io(8'h08, 8'h00);
    // comparator output is a live level, never stored
    hw_status = 8'h01;
    read_io(8'h08, 8'h20);
    hw_status = 8'h00;
    read_io(8'h08, 8'h00);
    // serial and usi flags: set-bit acts as a one-write, clear-bit leaves flags
    @(negedge clock);
    flag_set = 8'h1E;
    @(negedge clock);
    flag_set = 8'h00;
    read_io(8'h0B, 8'h60);
    acc(4'h3, 8'h0B, 3'h6, 8'h00, 1'b1);
    read_io(8'h0B, 8'h20);
    acc(4'h3, 8'h0E, 3'h0, 8'h00, 1'b1);
    read_io(8'h0E, 8'hE1);
    acc(4'h4, 8'h0E, 3'h5, 8'h00, 1'b1);
    acc(4'h2, 8'h0E, 3'h0, 8'h80, 1'b1);
    read_io(8'h0E, 8'h60);
    // an event held through the clearing write must win
    flag_set = 8'h08;
    acc(4'h2, 8'h0E, 3'h0, 8'h40, 1'b1);
    flag_set = 8'h00;
    read_io(8'h0E, 8'h60);
    // enable low freezes the bank: a write under it is lost
    core.stall(4'h2, 8'h13, 8'hFF);
    read_io(8'h13, SCR);
    // unused slots and reserved bits, written on purpose
    core.polite = 1'b0;
    acc(4'h2, 8'h05, 3'h0, 8'hFF, 1'b1);
    read_io(8'h05, 8'h00);
    acc(4'h2, 8'h12, 3'h0, 8'hFF, 1'b1);
    check("pd_out", {1'b0, pd_out}, 8'h7F);
    core.polite = 1'b1;
    acc(4'h2, 8'h11, 3'h0, 8'h55, 1'b1);
    check("pd_dir", {1'b0, pd_dir}, 8'h55);
    acc(4'h2, 8'h17, 3'h0, 8'hF0, 1'b1);
    check("pb_dir", pb_dir, 8'hF0);
    // pins pass two synchroniser stages; pin registers ignore writes
    pb_pins = 8'hC3;
    pd_pins = 7'h2A;
    repeat (3) @(negedge clock);
    acc(4'h2, 8'h16, 3'h0, 8'h00, 1'b1);
    read_io(8'h16, 8'hC3);
    read_io(8'h10, 8'h2A);
    // second reset in mid-run
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    check("pb_out", pb_out, 8'h00);
    read_io(8'h13, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
